// ==== rtl/step_generator_with_io_pins.sv ====
// step generator top: wishbone registers, pin cells and sequencer hookup
//
// Behaviour
// RULE1: format 0 step+direction, 1 up/down pulses, 2 quadrature.
// RULE2: quadrature walks a full gray cycle 00-01-11-10-00 per step.
// RULE3: enable low means no step pulses are produced.
// RULE4: step output is high during a step, low between steps.
// RULE5: step pulse lasts a programmable number of nanoseconds.
// RULE6: programmable minimum gap in nanoseconds between successive steps.
// RULE7: direction stable a programmable time before each step begins.
// RULE8: direction held unchanged a programmable time after each step ends.
// RULE9: signed count of issued steps is readable as position.
// RULE10: instance owns two to six pins, drives only step and direction.
// RULE11: after reset every general pin is an input.
// RULE12: drive-select 0 gives pulled-up input; output writes have no effect.
// RULE13: drive-select 1 makes an output styled by open-collector select.
// RULE14: polarity flip inverts output value on outputs only.
// RULE15: push-pull output drives pin to the value; readback undefined.
// RULE16: open-drain drives low on 0, releases on 1; level readable.
// RULE17: each pin offers its true level and complement for reading.
// RULE18: unclaimed pins, including disabled instance pins, are full general pins.
// RULE19: only full pins take drive-select and out; claimed take flip, open-drain.
// RULE20: count increments on positive steps, decrements on negative steps.
`timescale 1ns/1ps
module step_generator_with_io_pins #(
  parameter int unsigned PIN_COUNT = 6
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire logic [31:0]          wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic                 wb_we_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      wb_err_o,
  input  wire logic                 stepEnable,
  input  wire logic [PIN_COUNT-1:0] pinIn,
  output logic [PIN_COUNT-1:0]      pinOut,
  output logic [PIN_COUNT-1:0]      pinOe
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic                 ack;
    logic                 err;
    logic [31:0]          rdat;
    logic                 en;
    logic [1:0]           fmt;
    logic                 claim;
    logic [31:0]          lenNs;
    logic [31:0]          spaceNs;
    logic [31:0]          setupNs;
    logic [31:0]          holdNs;
    logic                 req;
    logic                 reqDir;
    logic [PIN_COUNT-1:0] pinDriveSelect;
    logic [PIN_COUNT-1:0] openCollectorSelect;
    logic [PIN_COUNT-1:0] flip;
    logic [PIN_COUNT-1:0] outVal;
    logic [PIN_COUNT-1:0] po;
    logic [PIN_COUNT-1:0] oe;
    logic [PIN_COUNT-1:0] inLvl;
  } top_t;

  top_t cur_ff;
  top_t nxt_cur;

  stepgen_pkg::step_cfg_t cfg;
  wire logic              coreBusy;
  wire logic              coreA;
  wire logic              coreB;
  wire logic signed [31:0] coreCount;
  wire logic              hit;
  wire logic [7:0]        ofs;

  assign cfg = '{en: cur_ff.en & stepEnable, fmt: cur_ff.fmt, lenNs: cur_ff.lenNs,
                 spaceNs: cur_ff.spaceNs, setupNs: cur_ff.setupNs, holdNs: cur_ff.holdNs};

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  step_core u_core (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .cfg     (cfg),
    .req     (cur_ff.req),
    .reqDir  (cur_ff.reqDir),
    .busy    (coreBusy),
    .outA    (coreA),
    .outB    (coreB),
    .count   (coreCount)
  );

  assign hit = wb_cyc_i && wb_stb_i && !cur_ff.ack && !cur_ff.err;
  assign ofs = wb_adr_i[7:0];

  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    laneMerge = r;
  endfunction

  function automatic logic [31:0] zext(input logic [PIN_COUNT-1:0] v);
    logic [31:0] r;
    r = 32'h0;
    r[PIN_COUNT-1:0] = v;
    zext = r;
  endfunction

  // ------------------------------------------------------------
  // bus and pin cells
  // ------------------------------------------------------------
  always_comb begin
    logic        drv;
    logic        val;
    logic        mapped;
    logic [31:0] w;
    drv    = 1'b0;
    val    = 1'b0;
    mapped = 1'b1;
    w      = 32'h0;
    nxt_cur      = cur_ff;
    nxt_cur.ack  = 1'b0;
    nxt_cur.err  = 1'b0;
    nxt_cur.inLvl = pinIn; //RULE17
    if (coreBusy) begin
      nxt_cur.req = 1'b0;
    end
    if (hit) begin
      case (ofs)
        stepgen_pkg::OFS_CTRL: begin
          w = {27'h0, cur_ff.claim, 1'b0, cur_ff.fmt, cur_ff.en};
        end
        stepgen_pkg::OFS_STEPLEN: w = cur_ff.lenNs;
        stepgen_pkg::OFS_STEPSPACE: w = cur_ff.spaceNs;
        stepgen_pkg::OFS_DIRSETUP: w = cur_ff.setupNs;
        stepgen_pkg::OFS_DIRHOLD: w = cur_ff.holdNs;
        stepgen_pkg::OFS_STEPCMD: w = {30'h0, cur_ff.reqDir, cur_ff.req};
        stepgen_pkg::OFS_POS: w = coreCount; //RULE9
        stepgen_pkg::OFS_STATUS: w = {31'h0, coreBusy};
        stepgen_pkg::OFS_PINDRV: w = zext(cur_ff.pinDriveSelect);
        stepgen_pkg::OFS_PINOC: w = zext(cur_ff.openCollectorSelect);
        stepgen_pkg::OFS_PININV: w = zext(cur_ff.flip);
        stepgen_pkg::OFS_PINOUT: w = zext(cur_ff.outVal);
        stepgen_pkg::OFS_PININ: w = zext(cur_ff.inLvl); //RULE17
        stepgen_pkg::OFS_PININN: w = zext(~cur_ff.inLvl); //RULE17
        default: mapped = 1'b0;
      endcase
      nxt_cur.rdat = w;
      nxt_cur.ack  = mapped;
      nxt_cur.err  = !mapped;
      if (wb_we_i && mapped) begin
        case (ofs)
          stepgen_pkg::OFS_CTRL: begin
            if (wb_sel_i[0]) begin
              nxt_cur.en    = wb_dat_i[stepgen_pkg::CTRL_EN];
              nxt_cur.fmt   = wb_dat_i[stepgen_pkg::CTRL_FMT_LO +: 2]; //RULE1
              nxt_cur.claim = wb_dat_i[stepgen_pkg::CTRL_CLAIM];
            end
          end
          stepgen_pkg::OFS_STEPLEN: nxt_cur.lenNs = laneMerge(cur_ff.lenNs, wb_dat_i, wb_sel_i);
          stepgen_pkg::OFS_STEPSPACE: begin
            nxt_cur.spaceNs = laneMerge(cur_ff.spaceNs, wb_dat_i, wb_sel_i);
          end
          stepgen_pkg::OFS_DIRSETUP: begin
            nxt_cur.setupNs = laneMerge(cur_ff.setupNs, wb_dat_i, wb_sel_i);
          end
          stepgen_pkg::OFS_DIRHOLD: nxt_cur.holdNs = laneMerge(cur_ff.holdNs, wb_dat_i, wb_sel_i);
          stepgen_pkg::OFS_STEPCMD: begin
            if (wb_sel_i[0] && wb_dat_i[stepgen_pkg::CMD_GO]) begin
              nxt_cur.req    = 1'b1;
              nxt_cur.reqDir = wb_dat_i[stepgen_pkg::CMD_DIR];
            end
          end
          stepgen_pkg::OFS_PINDRV: begin
            nxt_cur.pinDriveSelect = wb_dat_i[PIN_COUNT-1:0];
          end
          stepgen_pkg::OFS_PINOC: begin
            nxt_cur.openCollectorSelect = wb_dat_i[PIN_COUNT-1:0];
          end
          stepgen_pkg::OFS_PININV: nxt_cur.flip = wb_dat_i[PIN_COUNT-1:0];
          stepgen_pkg::OFS_PINOUT: nxt_cur.outVal = wb_dat_i[PIN_COUNT-1:0];
          default: begin
            nxt_cur.rdat = w;
          end
        endcase
      end
    end
    // pins 0 and 1 carry step and direction while claimed; others stay general
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (cur_ff.claim && i < 2) begin //RULE10 RULE18
        drv = 1'b1; //RULE19
        val = (i == 0) ? coreA : coreB;
      end else begin
        drv = cur_ff.pinDriveSelect[i]; //RULE12 RULE13 RULE19
        val = cur_ff.outVal[i];
      end
      val = val ^ cur_ff.flip[i]; //RULE14
      if (!drv) begin
        nxt_cur.po[i] = 1'b0; //RULE12
        nxt_cur.oe[i] = 1'b0;
      end else if (cur_ff.openCollectorSelect[i]) begin
        nxt_cur.po[i] = 1'b0; //RULE16
        nxt_cur.oe[i] = !val;
      end else begin
        nxt_cur.po[i] = val; //RULE15
        nxt_cur.oe[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= '{ack: 1'b0, err: 1'b0, rdat: 32'h0, en: 1'b0,
                  fmt: stepgen_pkg::FMT_STEPDIR, claim: 1'b0,
                  lenNs: stepgen_pkg::RST_TIME_NS, spaceNs: stepgen_pkg::RST_TIME_NS,
                  setupNs: stepgen_pkg::RST_TIME_NS, holdNs: stepgen_pkg::RST_TIME_NS,
                  req: 1'b0, reqDir: 1'b0,
                  pinDriveSelect: '0, //RULE11
                  openCollectorSelect: '0, flip: '0, outVal: '0,
                  po: '0, oe: '0, inLvl: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign wb_dat_o = cur_ff.rdat;
  assign wb_ack_o = cur_ff.ack;
  assign wb_err_o = cur_ff.err;
  assign pinOut   = cur_ff.po;
  assign pinOe    = cur_ff.oe;
endmodule

// ==== rtl/stepgen_pkg.sv ====
// shared constants, register map and types for the step generator with pin cells
package stepgen_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned NS_PER_S = 1000000000;
  localparam int unsigned CLK_NS = NS_PER_S / CLK_HZ;

  // register word offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STEPLEN = 8'h04;
  localparam logic [7:0] OFS_STEPSPACE = 8'h08;
  localparam logic [7:0] OFS_DIRSETUP = 8'h0c;
  localparam logic [7:0] OFS_DIRHOLD = 8'h10;
  localparam logic [7:0] OFS_STEPCMD = 8'h14;
  localparam logic [7:0] OFS_POS = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_PINDRV = 8'h20;
  localparam logic [7:0] OFS_PINOC = 8'h24;
  localparam logic [7:0] OFS_PININV = 8'h28;
  localparam logic [7:0] OFS_PINOUT = 8'h2c;
  localparam logic [7:0] OFS_PININ = 8'h30;
  localparam logic [7:0] OFS_PININN = 8'h34;

  // control register fields
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_FMT_LO = 1;
  localparam int unsigned CTRL_CLAIM = 4;

  // step command fields: write 1 at CMD_GO with direction at CMD_DIR
  localparam int unsigned CMD_GO = 0;
  localparam int unsigned CMD_DIR = 1;

  localparam logic [1:0] FMT_STEPDIR = 2'h0;
  localparam logic [1:0] FMT_UPDOWN = 2'h1;
  localparam logic [1:0] FMT_QUAD = 2'h2;

  localparam logic [31:0] RST_TIME_NS = 32'h0000_0000;

  typedef enum {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_SPACE} step_state_t;

  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } wb_req_t;

  typedef struct packed {
    logic        en;
    logic [1:0]  fmt;
    logic [31:0] lenNs;
    logic [31:0] spaceNs;
    logic [31:0] setupNs;
    logic [31:0] holdNs;
  } step_cfg_t;
endpackage

// ==== rtl/step_core.sv ====
// step pulse sequencer: timing, output formats and feedback count
`timescale 1ns/1ps
module step_core (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire stepgen_pkg::step_cfg_t cfg,
  input  wire logic                  req,
  input  wire logic                  reqDir,
  output logic                       busy,
  output logic                       outA,
  output logic                       outB,
  output logic signed [31:0]         count
);
  typedef struct packed {
    stepgen_pkg::step_state_t st;
    logic [31:0]              tmr;
    logic                     dir;
    logic                     a;
    logic                     b;
    logic [1:0]               gray;
    logic signed [31:0]       cnt;
  } core_t;

  core_t cur_ff;
  core_t nxt_cur;

  // ns to cycles, rounded up, never below one
  function automatic logic [31:0] nsCycles(input logic [31:0] ns);
    logic [32:0] c;
    c = ({1'b0, ns} + 33'(stepgen_pkg::CLK_NS - 1)) / 33'(stepgen_pkg::CLK_NS);
    nsCycles = (c == 33'h0) ? 32'h1 : c[31:0];
  endfunction

  // quadrature keeps its levels between steps; other formats pulse
  always_comb begin
    nxt_cur = cur_ff;
    if (cur_ff.tmr != 32'h0) begin
      nxt_cur.tmr = cur_ff.tmr - 32'h1;
    end
    case (cur_ff.st)
      stepgen_pkg::ST_IDLE: begin
        if (req && cfg.en) begin //RULE3
          nxt_cur.dir = reqDir;
          // direction moves at setup start, so it has settled before the step rises
          if (cfg.fmt == stepgen_pkg::FMT_STEPDIR) begin
            nxt_cur.b = reqDir; //RULE7
          end
          nxt_cur.st  = stepgen_pkg::ST_SETUP;
          nxt_cur.tmr = nsCycles(cfg.setupNs); //RULE7
        end
      end
      stepgen_pkg::ST_SETUP: begin
        if (!cfg.en) begin //RULE3
          nxt_cur.st = stepgen_pkg::ST_IDLE;
        end else if (cur_ff.tmr <= 32'h1) begin
          nxt_cur.st  = stepgen_pkg::ST_PULSE;
          nxt_cur.tmr = nsCycles(cfg.lenNs); //RULE5
          nxt_cur.cnt = cur_ff.dir ? cur_ff.cnt + 32'sh1 : cur_ff.cnt - 32'sh1; //RULE9 RULE20
          case (cfg.fmt) //RULE1
            stepgen_pkg::FMT_STEPDIR: begin
              nxt_cur.a = 1'b1; //RULE4
              nxt_cur.b = cur_ff.dir;
            end
            stepgen_pkg::FMT_UPDOWN: begin
              nxt_cur.a = cur_ff.dir;
              nxt_cur.b = !cur_ff.dir;
            end
            stepgen_pkg::FMT_QUAD: begin
              nxt_cur.gray = cur_ff.dir ? 2'h1 : 2'h3; //RULE2
              nxt_cur.a    = cur_ff.dir ? 1'b0 : 1'b1;
              nxt_cur.b    = cur_ff.dir ? 1'b1 : 1'b0;
            end
            default: begin
              nxt_cur.a = 1'b0;
            end
          endcase
        end
      end
      stepgen_pkg::ST_PULSE: begin
        if (cfg.fmt == stepgen_pkg::FMT_QUAD && cur_ff.gray != 2'h0) begin
          if (cur_ff.tmr <= 32'h1) begin
            // walk 00,01,11,10,00 forward, reverse for negative
            nxt_cur.gray = cur_ff.dir ? cur_ff.gray + 2'h1 : cur_ff.gray - 2'h1; //RULE2
            nxt_cur.a = (cur_ff.dir ? cur_ff.gray + 2'h1 : cur_ff.gray - 2'h1) >= 2'h2;
            nxt_cur.b = ((cur_ff.dir ? cur_ff.gray + 2'h1 : cur_ff.gray - 2'h1) == 2'h1)
                        || ((cur_ff.dir ? cur_ff.gray + 2'h1 : cur_ff.gray - 2'h1) == 2'h2);
            nxt_cur.tmr = nsCycles(cfg.lenNs);
          end
        end else if (cur_ff.tmr <= 32'h1) begin
          if (cfg.fmt != stepgen_pkg::FMT_QUAD) begin
            nxt_cur.a = 1'b0;
            if (cfg.fmt == stepgen_pkg::FMT_UPDOWN) begin
              nxt_cur.b = 1'b0;
            end
          end
          nxt_cur.st  = stepgen_pkg::ST_HOLD;
          nxt_cur.tmr = nsCycles(cfg.holdNs); //RULE8
        end
      end
      stepgen_pkg::ST_HOLD: begin
        if (cur_ff.tmr <= 32'h1) begin
          nxt_cur.st  = stepgen_pkg::ST_SPACE;
          nxt_cur.tmr = nsCycles(cfg.spaceNs); //RULE6
        end
      end
      stepgen_pkg::ST_SPACE: begin
        // hold already counted toward the gap, space runs on top for margin
        if (cur_ff.tmr <= 32'h1) begin
          nxt_cur.st = stepgen_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_cur.st = stepgen_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= '{st: stepgen_pkg::ST_IDLE, tmr: 32'h0, dir: 1'b0, a: 1'b0, b: 1'b0,
                  gray: 2'h0, cnt: 32'sh0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign busy  = cur_ff.st != stepgen_pkg::ST_IDLE;
  assign outA  = cur_ff.a;
  assign outB  = cur_ff.b;
  assign count = cur_ff.cnt;
endmodule

// ==== testbench/step_generator_with_io_pins_monitor.sv ====
// checker of bus answers, pin cells and step timing at the top ports
`timescale 1ns/1ps
module step_generator_with_io_pins_monitor #(
  parameter int unsigned PIN_COUNT = 6
) (
  input wire logic                 sys_clk,
  input wire logic                 rst_b,
  input wire logic [31:0]          wb_adr_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic [3:0]           wb_sel_i,
  input wire logic                 wb_we_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire logic                 wb_err_o,
  input wire logic                 stepEnable,
  input wire logic [PIN_COUNT-1:0] pinIn,
  input wire logic [PIN_COUNT-1:0] pinOut,
  input wire logic [PIN_COUNT-1:0] pinOe
);
  // ----------------------------------------
  // shadow of software settings
  // ----------------------------------------
  logic [PIN_COUNT-1:0] drv_ff, oc_ff, inv_ff, val_ff, gen, v, expOe, expOut;
  logic [4:0]           ctrl_ff;
  logic [31:0]          len_ff, lenCyc, hi_ff, sp_ff, spCyc, lo_ff;
  logic [1:0]           quiet_ff;
  logic                 take, wr, sd;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr   = take && wb_we_i;
  // pin cells lag a settings write, so pins are judged only once it has settled
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {ctrl_ff, len_ff, drv_ff, oc_ff, inv_ff, val_ff, quiet_ff, hi_ff, sp_ff, lo_ff} <= '0;
    end else begin
      if (wr) begin
        case (wb_adr_i[7:0])
          stepgen_pkg::OFS_CTRL:    ctrl_ff <= wb_dat_i[4:0];
          stepgen_pkg::OFS_STEPLEN: len_ff <= wb_dat_i;
          stepgen_pkg::OFS_STEPSPACE: sp_ff <= wb_dat_i;
          stepgen_pkg::OFS_PINDRV:  drv_ff <= wb_dat_i[PIN_COUNT-1:0];
          stepgen_pkg::OFS_PINOC:   oc_ff <= wb_dat_i[PIN_COUNT-1:0];
          stepgen_pkg::OFS_PININV:  inv_ff <= wb_dat_i[PIN_COUNT-1:0];
          stepgen_pkg::OFS_PINOUT:  val_ff <= wb_dat_i[PIN_COUNT-1:0];
          default: ;
        endcase
      end
      // step commands leave the pin cells alone, so they keep step checks armed
      quiet_ff <= (wr && wb_adr_i[7:0] != stepgen_pkg::OFS_STEPCMD) ? 2'h0
                  : quiet_ff + {1'b0, quiet_ff != 2'h3};
      hi_ff    <= pinOut[0] ? hi_ff + 32'h1 : 32'h0;
      lo_ff    <= pinOut[0] ? 32'h0 : lo_ff + 32'h1;
    end
  end
  function automatic logic [31:0] nsCyc(input logic [31:0] ns);
    nsCyc = (ns == 32'h0) ? 32'h1 : (ns + stepgen_pkg::CLK_NS - 1) / stepgen_pkg::CLK_NS;
  endfunction
  always_comb begin
    gen    = ctrl_ff[stepgen_pkg::CTRL_CLAIM] ? ~PIN_COUNT'(2'h3) : '1;
    v      = val_ff ^ inv_ff;
    expOe  = drv_ff & ~(oc_ff & v);
    expOut = v & ~oc_ff;
    lenCyc = nsCyc(len_ff);
    spCyc  = nsCyc(sp_ff);
    sd     = quiet_ff == 2'h3 && ctrl_ff[4] && ctrl_ff[2:1] == stepgen_pkg::FMT_STEPDIR
             && inv_ff[1:0] == 2'h0 && oc_ff[1:0] == 2'h0;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_stepLow;
    !pinOut[0] && !$past(pinOut[0]) ##1 !pinOut[0];
  endsequence
  property p_ackOnce; (wb_ack_o || wb_err_o) |=> !wb_ack_o && !wb_err_o; endproperty
  a_ackOnce: assert property (p_ackOnce)
    else $error("answer longer than one cycle");
  property p_answer; take |=> wb_ack_o != wb_err_o; endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered next cycle");
  property p_resetIdle; $rose(rst_b) |-> pinOe == '0 ##1 pinOe == '0; endproperty
  a_resetIdle: assert property (p_resetIdle)
    else $error("pin driven after reset");
  property p_genOe; quiet_ff == 2'h3 |-> ((pinOe ^ expOe) & gen) == '0; endproperty
  a_genOe: assert property (p_genOe)
    else $error("general pin enable wrong");
  property p_genOut; quiet_ff == 2'h3 |-> ((pinOut ^ expOut) & gen & pinOe) == '0; endproperty
  a_genOut: assert property (p_genOut)
    else $error("general pin value wrong");
  property p_enable;
    sd && $rose(pinOut[0]) |-> $past(stepEnable) || $past(stepEnable, 2) || $past(stepEnable, 3);
  endproperty
  a_enable: assert property (p_enable)
    else $error("step while disabled");
  property p_width; sd && $fell(pinOut[0]) |-> hi_ff == lenCyc; endproperty
  a_width: assert property (p_width)
    else $error("step pulse length wrong");
  property p_gap; sd && $rose(pinOut[0]) |-> lo_ff >= spCyc; endproperty
  a_gap: assert property (p_gap)
    else $error("steps closer than the minimum gap");
  property p_dirHold; sd && $changed(pinOut[1]) |-> s_stepLow; endproperty
  a_dirHold: assert property (p_dirHold)
    else $error("direction moved near a step");
endmodule

bind step_generator_with_io_pins step_generator_with_io_pins_monitor #(.PIN_COUNT(PIN_COUNT)) uMon (
  .sys_clk(sys_clk), .rst_b(rst_b), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .stepEnable(stepEnable), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));

// ==== testbench/pin_world.sv ====
// connector model: weak pull-ups, an open-drain neighbour and a step/dir motor driver
`timescale 1ns/1ps
module pin_world #(
  parameter int unsigned PIN_COUNT = 6
) (
  input  wire logic [PIN_COUNT-1:0] pinOut,
  input  wire logic [PIN_COUNT-1:0] pinOe,
  input  wire logic [PIN_COUNT-1:0] extLow,
  output logic [PIN_COUNT-1:0]      pinIn,
  output int                        steps
);
  // ----------------------------------------
  // wire level and motor driver
  // ----------------------------------------
  // neighbours may only pull low; a released line floats to the pull-up
  assign pinIn = ~extLow & (~pinOe | pinOut);
  initial steps = 0;
  always @(posedge pinIn[0]) steps <= steps + (pinIn[1] ? 1 : -1);
endmodule

// ==== testbench/step_generator_with_io_pins_tb.sv ====
// self-checking bench for the step generator with pin cells
`timescale 1ns/1ps
module step_generator_with_io_pins_tb;
  // ----------------------------------------
  // clock, design and connector
  // ----------------------------------------
  localparam int unsigned LEN_NS = 75;
  localparam logic [31:0] WIDTH  = 32'((LEN_NS + stepgen_pkg::CLK_NS - 1) / stepgen_pkg::CLK_NS);
  logic        sys_clk, rst_b, stepEnable, cyc, stb, we, ack, err, e;
  logic [31:0] adr, dat, rdat, q, cycles, hi, width, rise0, rise1, chg, r0, r1, c;
  logic [3:0]  sel;
  logic [5:0]  pinOut, pinOe, pinIn, extLow;
  logic [1:0]  prev;
  int          errors, comparisons, steps, base, expPos;
  always #12.5 sys_clk = ~sys_clk;
  step_generator_with_io_pins #(.PIN_COUNT(6)) DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .stepEnable(stepEnable), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
  pin_world #(.PIN_COUNT(6)) world (
    .pinOut(pinOut), .pinOe(pinOe), .extLow(extLow), .pinIn(pinIn), .steps(steps));
  always @(posedge sys_clk) begin
    cycles <= cycles + 32'h1;
    hi <= pinOut[0] ? hi + 32'h1 : 32'h0;
    if (!pinOut[0] && hi != 32'h0) width <= hi;
    rise0 <= rise0 + 32'(pinOut[0] & ~prev[0]);
    rise1 <= rise1 + 32'(pinOut[1] & ~prev[1]);
    if (pinOut[1:0] !== prev) chg <= chg + 32'h1;
    prev <= pinOut[1:0];
    if (cycles == 32'h4e20) begin
      errors++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // bus and checking tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // no local limit: only the cycle ceiling ends a wait that never gets an answer
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    {adr, we, dat, cyc, stb} <= {{24'h0, a}, w, d, 2'h3};
    do begin
      @(posedge sys_clk);
    end while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    e = err;
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] x);
    bus(a, 1'b0, 32'h0);
    check(name, q & 32'h3f, x);
  endtask
  task automatic step(input logic dir);
    wr(stepgen_pkg::OFS_STEPCMD, {30'h0, dir, 1'b1});
    do begin
      bus(stepgen_pkg::OFS_STATUS, 1'b0, 32'h0);
    end while (q[0] !== 1'b0);
    expPos += dir ? 1 : -1;
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {sys_clk, rst_b, stepEnable, cyc, stb, we} = '0;
    {adr, dat, cycles, hi, width, rise0, rise1, chg, extLow, prev} = '0;
    {sel, errors, comparisons, expPos} = {4'hf, 96'h0};
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    check("reset enables", 32'(pinOe), 32'h0);
    rd("reset drive select", stepgen_pkg::OFS_PINDRV, 32'h0);
    wr(stepgen_pkg::OFS_PINDRV, 32'h3f);
    wr(stepgen_pkg::OFS_PINOUT, 32'h15);
    check("push-pull enables", 32'(pinOe), 32'h3f);
    check("push-pull values", 32'(pinOut), 32'h15);
    wr(stepgen_pkg::OFS_PININV, 32'h3f);
    check("flipped values", 32'(pinOut), 32'h2a);
    wr(stepgen_pkg::OFS_PINOC, 32'h3f);
    wr(stepgen_pkg::OFS_PININV, 32'h0);
    extLow <= 6'h01;
    wr(stepgen_pkg::OFS_PINOUT, 32'h0f);
    check("open-drain enables", 32'(pinOe), 32'h30);
    check("open-drain drive", 32'(pinOut & pinOe), 32'h0);
    rd("open-drain level", stepgen_pkg::OFS_PININ, 32'h0e);
    rd("inverse level", stepgen_pkg::OFS_PININN, 32'h31);
    wr(stepgen_pkg::OFS_PINDRV, 32'h0);
    wr(stepgen_pkg::OFS_PINOUT, 32'h3f);
    extLow <= 6'h03;
    wr(stepgen_pkg::OFS_PININV, 32'h3f);
    check("input enables", 32'(pinOe), 32'h0);
    rd("input level", stepgen_pkg::OFS_PININ, 32'h3c);
    bus(8'h40, 1'b0, 32'h0);
    check("unmapped error", 32'(e), 32'h1);
    extLow <= 6'h0;
    wr(stepgen_pkg::OFS_PININV, 32'h0);
    wr(stepgen_pkg::OFS_PINOC, 32'h0);
    wr(stepgen_pkg::OFS_STEPLEN, LEN_NS);
    wr(stepgen_pkg::OFS_STEPSPACE, 32'h19);
    wr(stepgen_pkg::OFS_DIRSETUP, 32'h32);
    wr(stepgen_pkg::OFS_DIRHOLD, 32'h32);
    wr(stepgen_pkg::OFS_CTRL, 32'h11);
    check("claimed enables", 32'(pinOe), 32'h03);
    stepEnable <= 1'b1;
    base = steps;
    step(1'b1);
    step(1'b0);
    step(1'b0);
    rd("position", stepgen_pkg::OFS_POS, 32'(expPos) & 32'h3f);
    check("driver steps", 32'(steps - base), 32'(expPos));
    check("pulse width", width, WIDTH);
    for (int f = 1; f < 3; f++) begin
      for (int d = 0; d < 2; d++) begin
        wr(stepgen_pkg::OFS_CTRL, 32'h11 | 32'(f << 1));
        {r0, r1, c} = {rise0, rise1, chg};
        step(d[0]);
        check("first output pulses", rise0 - r0, 32'(f == 2 || d == 1));
        check("second output pulses", rise1 - r1, 32'(f == 2 || d == 0));
        if (f == 2) check("gray changes", chg - c, 32'h4);
      end
    end
    rd("position after formats", stepgen_pkg::OFS_POS, 32'(expPos) & 32'h3f);
    wr(stepgen_pkg::OFS_CTRL, 32'h11);
    stepEnable <= 1'b0;
    r0 = rise0;
    wr(stepgen_pkg::OFS_STEPCMD, 32'h3);
    repeat (40) @(posedge sys_clk);
    check("pulses while disabled", rise0 - r0, 32'h0);
    rd("position while disabled", stepgen_pkg::OFS_POS, 32'(expPos) & 32'h3f);
    give_verdict();
  end
endmodule
